// >>> rttc_core.sv
// Notes on behaviour
// [R1] sweep allows free run only; else halt
// [R2] hold inhibits outputs except srq, poll; in hold code raises srq on code error only, not on done
// [R3] poll in hold measures, refreshes, stays hold
// [R4] listed events leave hold
// [R5] leaving hold refreshes panel, new status
// [R6] immediate: one fast measurement, keep result
// [R7] listed events restart while result waits
// [R8] result read returns to hold
// [R9] settled: immediate after settling delay
// [R10] group trigger runs settled cycle
// [R11] clear key in hold runs settled cycle
// [R12] unread result overwritten by newer one
// [R13] free run restarts on bus commands
// [R14] triggered measurement blocks bus handshake
// [R15] one readout per measurement, chosen display
// [R16] errors and dc sent regardless of display
// [R17] auto setup zeroes special functions 1-8
// [R18] step codes follow last increment code
// [R19] controller reads before sending more codes
// [R20] talker until abort, other talk, untalk
// [R21] talk only sends each result, else remeasure
// [R22] status only sends status byte, clears it
// [R23] clear or entering remote gives free run
// [R24] two-bit mode plus pending flag
`include "rttc_regs.svh"

module rttc_core
  import rttc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `RTTC_SETTLE_US * `RTTC_CLK_MHZ
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire rttc_bus_ev_t bus_ev,
  input  wire rttc_switch_t switches,
  input  wire logic         data_mode,
  input  wire logic         lsn_accept,
  input  wire rttc_meas_t   meas,
  output logic              meas_start,
  output logic              meas_abort,
  output logic              hs_hold,
  output logic              disp_update,
  output logic              disp_refresh,
  output logic              xy_halt,
  output logic              srq,
  output logic              talk_valid,
  output logic [31:0]       talk_data,
  output logic              dav
);

  rttc_mode_t  mode;
  rttc_mst_t   mst;
  logic        pending;
  logic        poll_cyc;
  logic [19:0] settle_cnt;
  logic        sweep;
  logic        sel_right;
  logic        sel_level;
  logic        rd_avail;
  logic        talker;
  logic        cerr_flag;
  logic [31:0] inc;
  logic [31:0] freq;
  logic [31:0] level;
  logic [31:0] spcl;
  logic [7:0]  statb;
  logic [31:0] result;
  logic        res_err;
  logic        res_dc;
  logic        res_left_src;
  logic [7:0]  dph_addr;
  logic        dph_wr;

  logic        busy_trig;
  logic        cw;
  rttc_code_t  code;
  logic        clr_eff;
  logic        ev_ok;
  logic        to_free;
  logic        trig_imm;
  logic        trig_set;
  logic        restart_wait;
  logic        poll_go;
  logic        free_brk;
  logic        talk_only;
  logic        status_only;
  logic        sending;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `RTTC_OFS_STAT:   rd_mux = {20'h0_0000, talker, rd_avail, sel_level,
                                  sel_right, sweep, poll_cyc, pending,
                                  mst, mode, busy_trig};
      `RTTC_OFS_INC:    rd_mux = inc;
      `RTTC_OFS_FREQ:   rd_mux = freq;
      `RTTC_OFS_LEVEL:  rd_mux = level;
      `RTTC_OFS_SPCL:   rd_mux = spcl;
      `RTTC_OFS_STATB:  rd_mux = {24'h00_0000, statb};
      `RTTC_OFS_RESULT: rd_mux = result;
      default:          rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  // ahb-lite slave: zero wait states, read data captured at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      dph_wr    <= 1'b0;
      dph_addr  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dph_wr    <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        dph_wr   <= hwrite;
        dph_addr <= haddr;
        if (!hwrite) begin
          hrdata <= rd_mux(haddr);
        end
      end
    end
  end

  assign cw          = dph_wr && (dph_addr == `RTTC_OFS_CMD);
  assign code        = rttc_code_t'(hwdata[3:0]);
  assign busy_trig   = (mst == RTTC_M_SETTLE || mst == RTTC_M_MEAS) &&
                       (mode == RTTC_IMM || mode == RTTC_SET);
  assign ev_ok       = !busy_trig; // [R14]
  assign clr_eff     = ev_ok && bus_ev.clear_key && bus_ev.remote &&
                       !bus_ev.lockout;
  assign to_free     = ev_ok && (bus_ev.dcl || bus_ev.to_remote ||
                       bus_ev.go_local); // [R23]
  assign trig_imm    = cw && code == RTTC_C_IMM; // [R6]
  assign trig_set    = (cw && code == RTTC_C_SET) ||
                       (ev_ok && bus_ev.grp_trig) || // [R10]
                       (clr_eff && mode == RTTC_HOLD); // [R11]
  assign restart_wait = (mst == RTTC_M_WAIT) && ev_ok &&
                       (bus_ev.grp_trig || bus_ev.my_listen ||
                        clr_eff || cw); // [R7] [R19]
  assign poll_go     = ev_ok && bus_ev.serial_poll && mode == RTTC_HOLD &&
                       mst == RTTC_M_IDLE; // [R3]
  assign free_brk    = mode == RTTC_FREE && mst == RTTC_M_MEAS &&
                       (bus_ev.universal_cmd ||
                        (bus_ev.addressed_cmd && bus_ev.listened)); // [R13]
  assign talk_only   = switches.talk_only_switch &&
                       switches.addr != `RTTC_ADDR_ALL1;
  assign status_only = switches.talk_only_switch &&
                       switches.addr == `RTTC_ADDR_ALL1 &&
                       !switches.listen_only_switch;
  assign sending     = talk_valid && lsn_accept;

  // trigger mode [R24]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= RTTC_FREE;
    end else if (to_free) begin
      mode <= RTTC_FREE;
    end else if (cw && code <= RTTC_C_SET) begin
      mode <= rttc_mode_t'(code[1:0]); // [R4]
    end else if (trig_set || (restart_wait && mode == RTTC_HOLD)) begin
      mode <= RTTC_SET;
    end else if (sending && pending) begin
      mode <= RTTC_HOLD; // [R8]
    end
  end

  // measurement sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mst        <= RTTC_M_MEAS;
      settle_cnt <= 20'h0_0000;
      meas_start <= 1'b1;
      meas_abort <= 1'b0;
      poll_cyc   <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      meas_abort <= 1'b0;
      if (to_free || (cw && code == RTTC_C_FREE)) begin
        mst        <= RTTC_M_MEAS;
        meas_start <= 1'b1;
        meas_abort <= mst == RTTC_M_MEAS;
        poll_cyc   <= 1'b0;
      end else if (cw && code == RTTC_C_HOLD) begin
        mst        <= RTTC_M_IDLE;
        meas_abort <= mst == RTTC_M_MEAS;
      end else if (trig_set ||
                   (restart_wait && mode != RTTC_IMM)) begin
        mst        <= RTTC_M_SETTLE; // [R9]
        settle_cnt <= 20'(SETTLE_CYCLES - 1);
        meas_abort <= mst == RTTC_M_MEAS;
        poll_cyc   <= 1'b0;
      end else if (trig_imm || poll_go ||
                   (restart_wait && mode == RTTC_IMM)) begin
        mst        <= RTTC_M_MEAS;
        meas_start <= 1'b1;
        meas_abort <= mst == RTTC_M_MEAS;
        poll_cyc   <= poll_go;
      end else begin
        case (mst)
          RTTC_M_SETTLE: begin
            if (settle_cnt == 20'h0_0000) begin
              mst        <= RTTC_M_MEAS;
              meas_start <= 1'b1;
            end else begin
              settle_cnt <= settle_cnt - 20'h0_0001;
            end
          end
          RTTC_M_MEAS: begin
            if (free_brk) begin
              meas_abort <= 1'b1;
              meas_start <= 1'b1;
            end else if (meas.done) begin
              if (poll_cyc || mode == RTTC_HOLD) begin
                mst      <= RTTC_M_IDLE;
                poll_cyc <= 1'b0;
              end else if (mode == RTTC_FREE) begin
                meas_start <= 1'b1; // [R21]
              end else begin
                mst <= RTTC_M_WAIT;
              end
            end
          end
          RTTC_M_WAIT: begin
            if (sending) begin
              mst <= RTTC_M_IDLE;
            end
          end
          RTTC_M_IDLE: mst <= RTTC_M_IDLE;
          default:     mst <= RTTC_M_IDLE;
        endcase
      end
    end
  end

  // result capture and one readout per measurement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result       <= 32'h0000_0000;
      res_err      <= 1'b0;
      res_dc       <= 1'b0;
      res_left_src <= 1'b0;
      rd_avail     <= 1'b0;
      pending      <= 1'b0;
    end else if (mst == RTTC_M_MEAS && meas.done && !free_brk &&
                 !(mode == RTTC_HOLD && !poll_cyc)) begin
      res_err      <= meas.err;
      res_dc       <= meas.dc;
      res_left_src <= !sel_right && !meas.err && !meas.dc; // [R16]
      result       <= (sel_right || meas.dc || meas.err) ?
                      meas.right : meas.left; // [R15] [R12]
      rd_avail     <= !poll_cyc;
      pending      <= mode == RTTC_IMM || mode == RTTC_SET;
    end else if (sending || to_free || (cw && code == RTTC_C_HOLD)) begin
      rd_avail <= 1'b0;
      pending  <= 1'b0;
    end
  end

  // program codes: sweep, readout select, auto setup, steps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sweep     <= 1'b0;
      sel_right <= 1'b1;
      sel_level <= 1'b0;
      spcl      <= `RTTC_RST_SPCL;
      freq      <= `RTTC_RST_FREQ;
      level     <= `RTTC_RST_LEVEL;
      inc       <= `RTTC_RST_INC;
    end else begin
      if (ev_ok && bus_ev.dcl) begin
        sel_right <= 1'b1; // [R15]
      end
      if (cw) begin
        case (code)
          RTTC_C_SWEEP_ON:   sweep     <= 1'b1;
          RTTC_C_SWEEP_OFF:  sweep     <= 1'b0;
          RTTC_C_RIGHT:      sel_right <= 1'b1; // [R15]
          RTTC_C_LEFT:       sel_right <= 1'b0; // [R15]
          RTTC_C_AUTO_SETUP: spcl      <= 32'h0000_0000; // [R17]
          RTTC_C_FREQ_STEP:  sel_level <= 1'b0; // [R18]
          RTTC_C_LEVEL_STEP: sel_level <= 1'b1; // [R18]
          RTTC_C_STEP_UP: begin
            if (sel_level) level <= level + inc; // [R18]
            else           freq  <= freq + inc;
          end
          RTTC_C_STEP_DOWN: begin
            if (sel_level) level <= level - inc; // [R18]
            else           freq  <= freq - inc;
          end
          default: sweep <= sweep;
        endcase
      end
      if (dph_wr) begin
        case (dph_addr)
          `RTTC_OFS_INC:   inc   <= hwdata;
          `RTTC_OFS_FREQ:  freq  <= hwdata;
          `RTTC_OFS_LEVEL: level <= hwdata;
          `RTTC_OFS_SPCL:  spcl  <= hwdata;
          default:         inc   <= inc;
        endcase
      end
    end
  end

  // status byte: software set and hardware set win over send clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      statb     <= 8'h00;
      cerr_flag <= 1'b0;
    end else begin
      statb <= ((sending && status_only) || (ev_ok && bus_ev.dcl)) ?
               8'h00 : statb; // [R22]
      if (dph_wr && dph_addr == `RTTC_OFS_STATB) begin
        statb <= statb | hwdata[7:0];
      end
      if (mst == RTTC_M_MEAS && meas.done && mode != RTTC_HOLD) begin
        statb[`RTTC_STATB_DONE] <= 1'b1; // [R5]
      end
      if (bus_ev.code_err) begin
        statb[`RTTC_STATB_CERR] <= 1'b1;
        cerr_flag               <= 1'b1;
      end else if (ev_ok && bus_ev.dcl) begin
        cerr_flag <= 1'b0;
      end
    end
  end

  // talker state and instrument bus output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      talker     <= 1'b0;
      talk_valid <= 1'b0;
      talk_data  <= 32'h0000_0000;
      dav        <= 1'b0;
    end else begin
      if (ev_ok && (bus_ev.abort || bus_ev.other_talk || bus_ev.untalk)) begin
        talker <= 1'b0; // [R20]
      end else if (ev_ok && bus_ev.my_talk) begin
        talker <= 1'b1; // [R20]
      end
      dav <= sending; // [R22]
      if (status_only) begin
        talk_valid <= data_mode && !sending; // [R22]
        talk_data  <= {24'h00_0000, statb};
      end else begin
        talk_valid <= (talker || talk_only) && data_mode && rd_avail &&
                      !sending && !(mode == RTTC_HOLD && !pending); // [R2]
        talk_data  <= result;
      end
    end
  end

  // panel, recorder, service request and handshake outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_update  <= 1'b0;
      disp_refresh <= 1'b0;
      xy_halt      <= 1'b0;
      srq          <= 1'b0;
      hs_hold      <= 1'b0;
    end else begin
      disp_update  <= mst == RTTC_M_MEAS && meas.done && !free_brk &&
                      (mode != RTTC_HOLD || poll_cyc); // [R2] [R3]
      disp_refresh <= mode == RTTC_HOLD &&
                      (to_free || trig_set || trig_imm ||
                       (cw && code == RTTC_C_FREE)); // [R5]
      xy_halt      <= sweep && mode != RTTC_FREE; // [R1]
      srq          <= cerr_flag ||
                      (mode != RTTC_HOLD && statb[`RTTC_STATB_DONE]); // [R2]
      hs_hold      <= busy_trig; // [R14]
    end
  end

endmodule : rttc_core

// >>> rttc_core_props.sv
module rttc_core_props
  import rttc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        talk_valid,
  input wire logic [31:0] talk_data,
  input wire logic        lsn_accept,
  input wire logic        dav,
  input wire logic        meas_start,
  input wire logic        meas_abort,
  input wire logic        hs_hold,
  input wire rttc_meas_t  meas
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  accept_dav_a: assert property (
    talk_valid && lsn_accept |=> dav && !talk_valid)
    else $error("accepted word not followed by dav");
  dav_pulse_a: assert property (dav |=> !dav)
    else $error("dav wider than one cycle");
  dav_cause_a: assert property (
    $rose(dav) |-> $past(talk_valid) && $past(lsn_accept))
    else $error("dav without accepted word");
  word_stable_a: assert property (
    talk_valid && !lsn_accept ##1 talk_valid |-> $stable(talk_data))
    else $error("talk data changed while offered");
  trig_hold_a: assert property (
    hs_hold && !$past(meas.done) |=> hs_hold)
    else $error("handshake released before measurement done");
  no_interrupt_a: assert property (
    $past(hs_hold) && hs_hold |-> !meas_abort)
    else $error("triggered measurement aborted");
  abort_pulse_a: assert property (meas_abort |=> !meas_abort)
    else $error("abort wider than one cycle");
endmodule : rttc_core_props

bind rttc_core rttc_core_props #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) rttc_core_props_inst (
  .hclk      (hclk),
  .hresetn   (hresetn),
  .hreadyout (hreadyout),
  .hresp     (hresp),
  .talk_valid(talk_valid),
  .talk_data (talk_data),
  .lsn_accept(lsn_accept),
  .dav       (dav),
  .meas_start(meas_start),
  .meas_abort(meas_abort),
  .hs_hold   (hs_hold),
  .meas      (meas)
);

// >>> rttc_core_tb.sv
`include "rttc_regs.svh"

module rttc_core_tb
  import rttc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SET = 8;
  typedef struct {
    logic [3:0]  c;
    logic [31:0] m;
    logic [31:0] e;
  } rttc_row_t;
  rttc_row_t rows [8] = '{
    '{4'h1, 32'h6, 32'h2}, '{4'h0, 32'h6, 32'h0},
    '{4'h4, 32'h80, 32'h80}, '{4'h5, 32'h80, 32'h0},
    '{4'h7, 32'h100, 32'h0}, '{4'h6, 32'h100, 32'h100},
    '{4'hC, 32'h200, 32'h200}, '{4'hB, 32'h200, 32'h0}};

  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, talk_data;
  rttc_bus_ev_t bus_ev;
  rttc_switch_t switches;
  rttc_meas_t meas;
  logic data_mode, lsn_accept, meas_start, meas_abort, hs_hold, ready;
  logic disp_update, disp_refresh, xy_halt, srq, talk_valid, dav;
  int miscompares, n_tests;

  assign hready = hreadyout;
  always #25 hclk = ~hclk;

  rttc_core #(.SETTLE_CYCLES(SET)) rttc_core_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bus_ev(bus_ev), .switches(switches),
    .data_mode(data_mode), .lsn_accept(lsn_accept), .meas(meas),
    .meas_start(meas_start), .meas_abort(meas_abort), .hs_hold(hs_hold),
    .disp_update(disp_update), .disp_refresh(disp_refresh),
    .xy_halt(xy_halt), .srq(srq), .talk_valid(talk_valid),
    .talk_data(talk_data), .dav(dav));

  rttc_far_model rttc_far_model_inst (
    .hclk(hclk), .hresetn(hresetn), .meas_start(meas_start),
    .meas_abort(meas_abort), .talk_valid(talk_valid), .ready(ready),
    .meas(meas), .lsn_accept(lsn_accept));

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : rd

  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_hi

  task pulse(input int b);
    bus_ev[b] <= 1'b1;
    @(posedge hclk);
    bus_ev[b] <= 1'b0;
  endtask : pulse

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    final_report;
  end

  initial begin
    int n;
    logic [31:0] d;
    hclk = 0;
    hresetn = 0;
    {hsel, hwrite, htrans, haddr, hwdata, data_mode, ready} = '0;
    hsize = 3'h2;
    switches = '0;
    bus_ev = '0;
    bus_ev.remote = 1'b1;
    bus_ev.listened = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`RTTC_OFS_INC, d);
    chk("inc", d, `RTTC_RST_INC);
    rd(`RTTC_OFS_FREQ, d);
    chk("freq", d, `RTTC_RST_FREQ);
    rd(`RTTC_OFS_SPCL, d);
    chk("spcl", d, `RTTC_RST_SPCL);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(`RTTC_OFS_CMD, {28'h0, rows[i].c});
      rd(`RTTC_OFS_STAT, d);
      chk("stat", d & rows[i].m, rows[i].e);
    end
    $display("test codes done");
    wr(`RTTC_OFS_CMD, 32'h9);
    rd(`RTTC_OFS_FREQ, d);
    chk("step up", d, 32'h0000_07D0);
    wr(`RTTC_OFS_CMD, 32'hC);
    wr(`RTTC_OFS_LEVEL, 32'h0000_1000);
    wr(`RTTC_OFS_CMD, 32'hA);
    rd(`RTTC_OFS_LEVEL, d);
    chk("step down", d, 32'h0000_0C18);
    wr(`RTTC_OFS_SPCL, 32'hFFFF_FFFF);
    wr(`RTTC_OFS_CMD, 32'h8);
    rd(`RTTC_OFS_SPCL, d);
    chk("auto setup", d, 32'h0);
    wr(`RTTC_OFS_CMD, 32'h4);
    wr(`RTTC_OFS_CMD, 32'h1);
    repeat (2) @(posedge hclk);
    chk("xy halt", {31'h0, xy_halt}, 32'h1);
    wr(`RTTC_OFS_CMD, 32'h5);
    wr(`RTTC_OFS_CMD, 32'h0);
    $display("test setup codes done");
    pulse(9);
    data_mode <= 1'b1;
    ready <= 1'b1;
    wr(`RTTC_OFS_CMD, 32'h1);
    repeat (20) @(posedge hclk);
    chk("hold quiet", {31'h0, talk_valid}, 32'h0);
    pulse(5);
    wait_hi(meas_start, n);
    chk("poll start", {31'h0, meas_start}, 32'h1);
    wait_hi(disp_update, n);
    chk("poll update", {31'h0, disp_update}, 32'h1);
    rd(`RTTC_OFS_STAT, d);
    chk("poll hold", d & 32'h6, 32'h2);
    wr(`RTTC_OFS_CMD, 32'h2);
    @(posedge hclk);
    chk("refresh", {31'h0, disp_refresh}, 32'h1);
    wait_hi(talk_valid, n);
    chk("result", talk_data, 32'h0000_1234);
    wait_hi(dav, n);
    rd(`RTTC_OFS_STAT, d);
    chk("read hold", d & 32'h6, 32'h2);
    $display("test hold done");
    // group trigger, then front-panel key: both run a settled cycle
    for (int k = 0; k < 2; k++) begin
      pulse(k == 0 ? 11 : 1);
      wait_hi(meas_start, n);
      chk("settle", {31'h0, n == SET + 1}, 32'h1);
      @(posedge hclk);
      chk("hs hold", {31'h0, hs_hold}, 32'h1);
      wait_hi(dav, n);
      rd(`RTTC_OFS_STAT, d);
      chk("trig hold", d & 32'h6, 32'h2);
    end
    pulse(14);
    rd(`RTTC_OFS_STAT, d);
    chk("clear", d & 32'h6, 32'h0);
    pulse(4);
    @(posedge hclk);
    chk("free break", {30'h0, meas_abort, meas_start}, 32'h3);
    $display("test trigger done");
    data_mode <= 1'b0;
    wr(`RTTC_OFS_CMD, 32'h1);
    switches <= '{1'b1, 1'b0, `RTTC_ADDR_ALL1};
    pulse(0);
    repeat (2) @(posedge hclk);
    chk("srq in hold", {31'h0, srq}, 32'h1);
    data_mode <= 1'b1;
    wait_hi(talk_valid, n);
    chk("status copy", talk_data, 32'h0000_0002);
    wait_hi(dav, n);
    rd(`RTTC_OFS_STATB, d);
    chk("status clear", d, 32'h0);
    $display("test status only done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`RTTC_OFS_STAT, d);
    chk("rereset", d & 32'h6, 32'h0);
    $display("test rereset done");
    final_report;
  end
endmodule : rttc_core_tb

// >>> rttc_far_model.sv
module rttc_far_model
  import rttc_pkg::*;
#(
  parameter int DLY = 4
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic meas_start,
  input  wire logic meas_abort,
  input  wire logic talk_valid,
  input  wire logic ready,
  output rttc_meas_t meas,
  output logic       lsn_accept
);
  logic [7:0] cnt;

  // measurement engine: a start restarts, an abort alone drops the cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      meas <= '0;
    end else begin
      meas.done <= 1'b0;
      if (meas_start) begin
        cnt <= DLY[7:0];
      end else if (meas_abort) begin
        cnt <= 8'h00;
      end else if (cnt == 8'h01) begin
        cnt <= 8'h00;
        meas.done <= 1'b1;
        meas.right <= 32'h0000_1234;
        meas.left <= 32'h0000_5678;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // listener takes one word per offer, only while ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsn_accept <= 1'b0;
    end else begin
      lsn_accept <= talk_valid & ready & ~lsn_accept;
    end
  end
endmodule : rttc_far_model

// >>> rttc_pkg.sv
package rttc_pkg;

  typedef enum logic [1:0] {
    RTTC_FREE = 2'h0,
    RTTC_HOLD = 2'h1,
    RTTC_IMM  = 2'h2,
    RTTC_SET  = 2'h3
  } rttc_mode_t;

  typedef enum logic [1:0] {
    RTTC_M_IDLE   = 2'h0,
    RTTC_M_SETTLE = 2'h1,
    RTTC_M_MEAS   = 2'h2,
    RTTC_M_WAIT   = 2'h3
  } rttc_mst_t;

  typedef enum logic [3:0] {
    RTTC_C_FREE       = 4'h0,
    RTTC_C_HOLD       = 4'h1,
    RTTC_C_IMM        = 4'h2,
    RTTC_C_SET        = 4'h3,
    RTTC_C_SWEEP_ON   = 4'h4,
    RTTC_C_SWEEP_OFF  = 4'h5,
    RTTC_C_RIGHT      = 4'h6,
    RTTC_C_LEFT       = 4'h7,
    RTTC_C_AUTO_SETUP = 4'h8,
    RTTC_C_STEP_UP    = 4'h9,
    RTTC_C_STEP_DOWN  = 4'hA,
    RTTC_C_FREQ_STEP  = 4'hB,
    RTTC_C_LEVEL_STEP = 4'hC
  } rttc_code_t;

  // events and levels decoded from the instrument bus by the interface logic
  typedef struct packed {
    logic remote;
    logic lockout;
    logic dcl;
    logic to_remote;
    logic go_local;
    logic grp_trig;
    logic my_listen;
    logic my_talk;
    logic other_talk;
    logic untalk;
    logic abort;
    logic serial_poll;
    logic universal_cmd;
    logic addressed_cmd;
    logic listened;
    logic clear_key;
    logic code_err;
  } rttc_bus_ev_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic        dc;
    logic [31:0] right;
    logic [31:0] left;
  } rttc_meas_t;

  typedef struct packed {
    logic       talk_only_switch;
    logic       listen_only_switch;
    logic [4:0] addr;
  } rttc_switch_t;

endpackage : rttc_pkg

// >>> rttc_regs.svh
`ifndef RTTC_REGS_SVH
`define RTTC_REGS_SVH

`define RTTC_OFS_CMD      8'h00
`define RTTC_OFS_STAT     8'h04
`define RTTC_OFS_INC      8'h08
`define RTTC_OFS_FREQ     8'h0C
`define RTTC_OFS_LEVEL    8'h10
`define RTTC_OFS_SPCL     8'h14
`define RTTC_OFS_STATB    8'h18
`define RTTC_OFS_RESULT   8'h1C

`define RTTC_STATB_DONE   0
`define RTTC_STATB_CERR   1

`define RTTC_RST_INC      32'h0000_03E8
`define RTTC_RST_FREQ     32'h0000_03E8
`define RTTC_RST_LEVEL    32'h0000_0000
`define RTTC_RST_SPCL     32'h0000_0000
`define RTTC_ADDR_ALL1    5'h1F

`define RTTC_CLK_MHZ      20
`define RTTC_SETTLE_US    5000

`endif
